// ===== hdl/adcp_top.sv
/*
 * Converter control registers, conversion sequencing, result alignment,
 * conversion clock enable and charge pump enable, behind an AHB-Lite slave.
 * Assumes the analog core and timers run on hclk; the supply comparator,
 * the RC oscillator and the trigger sources are resynchronised here.
 */
// Operation
// - Start write begins conversion; flag stays set
// - Hardware clears start flag at completion
// - Enable bit powers converter, zero disables
// - Channel field routes chosen input to converter
// - Align one: right-justified, high byte padded
// - Align zero: left-justified, low byte padded
// - Clock field picks divider or RC clock
// - Reference field picks positive reference source
// - Trigger field selects auto-conversion source
// - Code 1101: high byte read triggers
// - Rising trigger edge sets the start flag
// - Result bytes readable at own addresses
// - Pump mode 11 enables pump always
// - Pump mode 10 follows supply-below indication
// - Pump mode 01 needs converter on, supply low
// - Pump mode resets to 00, which disables
module adcp_top
  import adcp_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [ADDR_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  conv_done,
  input  wire logic [RESULT_W-1:0]   conv_data,
  input  wire logic                  rc_osc,
  input  wire logic [TRIG_SRC_N-1:0] trigger_src,
  input  wire logic                  supply_below,
  output logic                       adc_power,
  output logic [5:0]                 input_channel_sel,
  output logic [1:0]                 pos_ref_sel,
  output logic                       conv_start,
  output logic                       conv_clk_en,
  output logic                       pump_enable
);

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    case (sel)
      CLK_DIV2:  div_mask = 6'h01;
      CLK_DIV4:  div_mask = 6'h03;
      CLK_DIV8:  div_mask = 6'h07;
      CLK_DIV16: div_mask = 6'h0f;
      CLK_DIV32: div_mask = 6'h1f;
      CLK_DIV64: div_mask = 6'h3f;
      default:   div_mask = 6'h00;
    endcase
  endfunction

  function automatic logic [15:0] align(input logic right, input logic [RESULT_W-1:0] d);
    align = right ? {6'h00, d} : {d, 6'h00};
  endfunction

  // Level of the selected source; codes outside 1..9 select nothing
  function automatic logic trig_pick(input logic [3:0]            sel,
                                     input logic [TRIG_SRC_N-1:0] lvl);
    trig_pick = 1'b0;
    for (int i = 1; i < TRIG_SRC_N; i++) begin
      if (sel == 4'(i)) begin
        trig_pick = lvl[i];
      end
    end
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic [5:0]  chan_q;
  logic        on_q;
  logic [2:0]  clk_sel_q;
  logic [1:0]  ref_q;
  logic        align_q;
  logic [3:0]  trigger_sel;
  logic [1:0]  pump_mode;
  logic [15:0] result_q;
  adcp_conv_t  conv_state;
  adcp_conv_t  next_conv_state;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [TRIG_SRC_N-1:0] trig_s1;
  logic [TRIG_SRC_N-1:0] trig_s2;
  logic                  below_s1;
  logic                  below_s2;
  logic                  rc_s1;
  logic                  rc_s2;
  logic                  rc_prev;
  logic                  trig_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_s1  <= '0;
      trig_s2  <= '0;
      below_s1 <= 1'b0;
      below_s2 <= 1'b0;
      rc_s1    <= 1'b0;
      rc_s2    <= 1'b0;
    end else begin
      trig_s1  <= trigger_src;
      trig_s2  <= trig_s1;
      below_s1 <= supply_below;
      below_s2 <= below_s1;
      rc_s1    <= rc_osc;
      rc_s2    <= rc_s1;
    end
  end

  // ==========================================================
  // Bus decode
  // ==========================================================
  // Size is not decoded: every register is one aligned word
  wire             bus_acc  = hsel & htrans[1] & hready;
  wire             rd_acc   = bus_acc & ~hwrite;
  wire [ADDR_W-1:0] a       = haddr;
  logic            wr_pend;
  logic [ADDR_W-1:0] wr_addr;

  wire wr_ctrl_a = wr_pend & (wr_addr == reg_addr(IDX_ADC_CTRL_A));
  wire wr_ctrl_b = wr_pend & (wr_addr == reg_addr(IDX_ADC_CTRL_B));
  wire wr_trig   = wr_pend & (wr_addr == reg_addr(IDX_AUTO_TRIGGER_SEL));
  wire wr_pump   = wr_pend & (wr_addr == reg_addr(IDX_PUMP_CONTROL_REG));
  wire wr_res_lo = wr_pend & (wr_addr == reg_addr(IDX_RESULT_LOW_BYTE));
  wire wr_res_hi = wr_pend & (wr_addr == reg_addr(IDX_RESULT_HIGH_BYTE));

  wire go_flag   = (conv_state == CONV_RUN);

  // Address-phase register hits
  wire hit_res_lo = (a == reg_addr(IDX_RESULT_LOW_BYTE));
  wire hit_res_hi = (a == reg_addr(IDX_RESULT_HIGH_BYTE));
  wire hit_ctrl_a = (a == reg_addr(IDX_ADC_CTRL_A));
  wire hit_ctrl_b = (a == reg_addr(IDX_ADC_CTRL_B));
  wire hit_trig   = (a == reg_addr(IDX_AUTO_TRIGGER_SEL));
  wire hit_pump   = (a == reg_addr(IDX_PUMP_CONTROL_REG));

  // Register images as software sees them
  wire [7:0] ctrl_a_img = {chan_q, go_flag, on_q};
  wire [7:0] ctrl_b_img = {align_q, clk_sel_q, 2'b00, ref_q};
  wire [7:0] trig_img   = {4'h0, trigger_sel};
  wire [7:0] pump_img   = {pump_mode, 6'h00};

  // Read data, selected in the address phase; unmapped reads as zero
  logic [7:0] rd_byte;
  assign rd_byte =
      hit_res_lo ? result_q[7:0]  :
      hit_res_hi ? result_q[15:8] :
      hit_ctrl_a ? ctrl_a_img     :
      hit_ctrl_b ? ctrl_b_img     :
      hit_trig   ? trig_img       :
      hit_pump   ? pump_img       :
      8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= bus_acc & hwrite;
      wr_addr   <= haddr;
      hrdata    <= rd_acc ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================
  // Auto-conversion trigger
  // ==========================================================
  wire trig_code_ok = (trigger_sel != TRIG_NONE) && (trigger_sel <= TRIG_LAST_SRC);
  // A change of select can itself look like a rising edge
  wire trig_lvl     = trig_code_ok & trig_pick(trigger_sel, trig_s2);
  wire trig_rise    = trig_lvl & ~trig_prev;
  wire hi_read_evt  = rd_acc & hit_res_hi & (trigger_sel == TRIG_HIGH_READ);
  wire auto_evt     = trig_rise | hi_read_evt;

  // ==========================================================
  // Conversion sequencing
  // ==========================================================
  wire next_on   = wr_ctrl_a ? hwdata[CTRL_A_ON_BIT] : on_q;
  wire sw_start  = wr_ctrl_a & hwdata[CTRL_A_GO_BIT];
  wire start_req = (sw_start | auto_evt) & next_on;
  wire finish    = go_flag & conv_done;
  wire launch    = start_req & (~go_flag | conv_done);

  always_comb begin
    next_conv_state = conv_state;
    if (!next_on) begin
      next_conv_state = CONV_IDLE;
    end else begin
      case (conv_state)
        CONV_IDLE: begin
          if (launch) begin
            next_conv_state = CONV_RUN;
          end
        end
        CONV_RUN: begin
          // A new start in the finishing cycle wins over the clear
          if (conv_done && !launch) begin
            next_conv_state = CONV_IDLE;
          end
        end
        default: next_conv_state = CONV_IDLE;
      endcase
    end
  end

  wire [15:0] aligned = align(align_q, conv_data);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_state <= CONV_IDLE;
      conv_start <= 1'b0;
      trig_prev  <= 1'b0;
    end else begin
      conv_state <= next_conv_state;
      conv_start <= launch;
      trig_prev  <= trig_lvl;
    end
  end

  // ==========================================================
  // Software registers and result
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_q      <= CTRL_A_RESET[CTRL_A_CHAN_MSB:CTRL_A_CHAN_LSB];
      on_q        <= CTRL_A_RESET[CTRL_A_ON_BIT];
      align_q     <= CTRL_B_RESET[CTRL_B_ALIGN_BIT];
      clk_sel_q   <= CTRL_B_RESET[CTRL_B_CLK_MSB:CTRL_B_CLK_LSB];
      ref_q       <= CTRL_B_RESET[CTRL_B_REF_MSB:CTRL_B_REF_LSB];
      trigger_sel <= TRIG_RESET;
      pump_mode   <= PUMP_RESET;
    end else begin
      if (wr_ctrl_a) begin
        chan_q <= hwdata[CTRL_A_CHAN_MSB:CTRL_A_CHAN_LSB];
        on_q   <= hwdata[CTRL_A_ON_BIT];
      end
      if (wr_ctrl_b) begin
        align_q   <= hwdata[CTRL_B_ALIGN_BIT];
        clk_sel_q <= hwdata[CTRL_B_CLK_MSB:CTRL_B_CLK_LSB];
        ref_q     <= hwdata[CTRL_B_REF_MSB:CTRL_B_REF_LSB];
      end
      if (wr_trig) begin
        trigger_sel <= hwdata[TRIG_SEL_MSB:TRIG_SEL_LSB];
      end
      if (wr_pump) begin
        pump_mode <= hwdata[PUMP_MODE_MSB:PUMP_MODE_LSB];
      end
    end
  end

  // Completion capture takes priority over a software byte write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= RESULT_RESET;
    end else if (finish) begin
      result_q <= aligned;
    end else begin
      if (wr_res_lo) begin
        result_q[7:0] <= hwdata[7:0];
      end
      if (wr_res_hi) begin
        result_q[15:8] <= hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Conversion clock enable
  // ==========================================================
  // RC codes tick once per resynchronised oscillator rising edge
  logic [5:0] div_cnt;
  wire        sel_rc  = (clk_sel_q == CLK_RC_A) || (clk_sel_q == CLK_RC_B);
  wire [5:0]  mask    = div_mask(clk_sel_q);
  wire        div_hit = ((div_cnt & mask) == mask);
  wire        rc_rise = rc_s2 & ~rc_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt     <= 6'h00;
      rc_prev     <= 1'b0;
      conv_clk_en <= 1'b0;
    end else begin
      div_cnt     <= on_q ? div_cnt + 6'h01 : 6'h00;
      rc_prev     <= rc_s2;
      conv_clk_en <= on_q & (sel_rc ? rc_rise : div_hit);
    end
  end

  // ==========================================================
  // Analog-side outputs and charge pump
  // ==========================================================
  // Supply level is the resynchronised comparator output
  logic next_pump;
  always_comb begin
    case (pump_mode)
      PUMP_ON:     next_pump = 1'b1;
      PUMP_AUTO:   next_pump = below_s2;
      PUMP_ANALOG: next_pump = on_q & below_s2;
      default:     next_pump = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_power         <= 1'b0;
      input_channel_sel <= 6'h00;
      pos_ref_sel       <= 2'h0;
      pump_enable       <= 1'b0;
    end else begin
      adc_power         <= next_on;
      input_channel_sel <= wr_ctrl_a ? hwdata[CTRL_A_CHAN_MSB:CTRL_A_CHAN_LSB]
                                     : chan_q;
      pos_ref_sel       <= ref_q;
      pump_enable       <= next_pump;
    end
  end

endmodule

// ===== hdl/adcp_pkg.sv
/*
 * Constants for the converter control and charge pump enable block:
 * register indices, field positions, reset values and code points.
 * Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
 */
package adcp_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [7:0] IDX_PUMP_CONTROL_REG = 8'h9a;
  localparam logic [7:0] IDX_RESULT_LOW_BYTE  = 8'h9b;
  localparam logic [7:0] IDX_RESULT_HIGH_BYTE = 8'h9c;
  localparam logic [7:0] IDX_ADC_CTRL_A       = 8'h9d;
  localparam logic [7:0] IDX_ADC_CTRL_B       = 8'h9e;
  localparam logic [7:0] IDX_AUTO_TRIGGER_SEL = 8'h9f;

  localparam int ADDR_W = 10;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_A_ON_BIT     = 0;
  localparam int CTRL_A_GO_BIT     = 1;
  localparam int CTRL_A_CHAN_LSB   = 2;
  localparam int CTRL_A_CHAN_MSB   = 7;
  localparam int CTRL_B_REF_LSB    = 0;
  localparam int CTRL_B_REF_MSB    = 1;
  localparam int CTRL_B_CLK_LSB    = 4;
  localparam int CTRL_B_CLK_MSB    = 6;
  localparam int CTRL_B_ALIGN_BIT  = 7;
  localparam int TRIG_SEL_LSB      = 0;
  localparam int TRIG_SEL_MSB      = 3;
  localparam int PUMP_MODE_LSB     = 6;
  localparam int PUMP_MODE_MSB     = 7;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0]  CTRL_A_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_B_RESET   = 8'h00;
  localparam logic [3:0]  TRIG_RESET     = 4'h0;
  localparam logic [1:0]  PUMP_RESET     = 2'h0;
  localparam logic [15:0] RESULT_RESET   = 16'h0000;

  // ==========================================================
  // Code points
  // ==========================================================
  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_RC_A  = 3'h3;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [2:0] CLK_RC_B  = 3'h7;

  localparam logic [3:0] TRIG_NONE      = 4'h0;
  localparam logic [3:0] TRIG_LAST_SRC  = 4'h9;
  localparam logic [3:0] TRIG_HIGH_READ = 4'hd;
  localparam int         TRIG_SRC_N     = 10;

  localparam logic [1:0] PUMP_OFF       = 2'h0;
  localparam logic [1:0] PUMP_ANALOG    = 2'h1;
  localparam logic [1:0] PUMP_AUTO      = 2'h2;
  localparam logic [1:0] PUMP_ON        = 2'h3;

  localparam int RESULT_W = 10;

  typedef enum logic {CONV_IDLE, CONV_RUN} adcp_conv_t;

endpackage

// ===== tb/adcp_properties.sv
/*
  Port checker for adcp_top: control writes, start pulse, clock gating, pump.
  Assumes one hclk domain, zero-wait AHB-Lite, bound to the top by the bench.
*/
module adcp_properties
  import adcp_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              adc_power,
  input wire logic [5:0]        input_channel_sel,
  input wire logic [1:0]        pos_ref_sel,
  input wire logic              conv_start,
  input wire logic              conv_clk_en,
  input wire logic              pump_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire wr_ph = hsel && htrans[1] && hwrite && hready;

  // ==========================================================
  // Write address phase, then its data phase
  // ==========================================================
  sequence wr_to(logic [7:0] idx);
    wr_ph && haddr == {idx, 2'b00} ##1 1'b1;
  endsequence

  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  start_power_a: assert property (conv_start |-> adc_power)
    else $error("conversion started while unpowered");
  power_wr_a: assert property (wr_to(IDX_ADC_CTRL_A) |=> adc_power == $past(hwdata[0]))
    else $error("power does not follow enable write");
  chan_wr_a: assert property (wr_to(IDX_ADC_CTRL_A) |=>
    input_channel_sel == $past(hwdata[7:2]))
    else $error("channel does not follow write");
  ref_wr_a: assert property (wr_to(IDX_ADC_CTRL_B) |=> ##1
    pos_ref_sel == $past(hwdata[1:0], 2))
    else $error("reference does not follow write");
  clk_off_a: assert property (!adc_power && !$past(adc_power) |-> !conv_clk_en)
    else $error("conversion clock while unpowered");
  pump_on_a: assert property (wr_to(IDX_PUMP_CONTROL_REG) ##0 hwdata[7:6] == 2'b11
    |-> ##[2:3] pump_enable)
    else $error("pump not enabled by mode 11");
  pump_off_a: assert property (wr_to(IDX_PUMP_CONTROL_REG) ##0 hwdata[7:6] == 2'b00
    |-> ##2 !pump_enable)
    else $error("pump not disabled by mode 00");
endmodule

// ===== tb/adcp_analog_model.sv
/*
  Analog core model: answers each start with a done pulse and a sample.
  Assumes hclk timing; slow selects a long conversion, power loss aborts.
*/
module adcp_analog_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       conv_start,
  input  wire logic       adc_power,
  input  wire logic       slow,
  input  wire logic [9:0] sample,
  output logic            conv_done,
  output logic [9:0]      conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy;
  logic [4:0] left;
  logic [9:0] last;

  // Data line shows the inverse of the last sample outside the done cycle
  assign conv_data = conv_done ? last : ~last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy      <= 1'b0;
      left      <= 5'h00;
      last      <= 10'h000;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        busy <= 1'b1;
        left <= slow ? 5'h0c : 5'h02;
      end else if (busy && !adc_power) begin
        busy <= 1'b0;
      end else if (busy && left == 5'h00) begin
        busy      <= 1'b0;
        conv_done <= 1'b1;
        last      <= sample;
      end else if (busy) begin
        left <= left - 5'h01;
      end
    end
  end
endmodule

// ===== tb/adcp_top_tb.sv
/*
  Self-checking bench for adcp_top with the analog core model.
  Assumes zero-wait AHB-Lite singles and hclk at 25 MHz.
*/
module adcp_top_tb
  import adcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  hclk, hresetn, hsel, hwrite, hready, hresp, rc_osc, supply_below;
  logic                  conv_done, adc_power, conv_start, conv_clk_en, pump_enable, slow;
  logic [ADDR_W-1:0]     haddr;
  logic [1:0]            htrans, pos_ref_sel;
  logic [2:0]            hsize;
  logic [31:0]           hwdata, hrdata;
  logic [9:0]            conv_data, sample;
  logic [TRIG_SRC_N-1:0] trigger_src;
  logic [5:0]            input_channel_sel;
  int                    n_errors, check_count, cycles, starts;

  adcp_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .conv_done(conv_done), .conv_data(conv_data),
    .rc_osc(rc_osc), .trigger_src(trigger_src), .supply_below(supply_below),
    .adc_power(adc_power), .input_channel_sel(input_channel_sel), .pos_ref_sel(pos_ref_sel),
    .conv_start(conv_start), .conv_clk_en(conv_clk_en), .pump_enable(pump_enable));
  adcp_analog_model core (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
    .adc_power(adc_power), .slow(slow), .sample(sample), .conv_done(conv_done),
    .conv_data(conv_data));

  always #20 hclk = ~hclk;
  always #163 rc_osc = ~rc_osc;

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1) starts <= starts + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // ==========================================================
  // Bus and compare tasks
  // ==========================================================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1; haddr <= {i, 2'b00}; htrans <= 2'b10; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    xfer(i, 1'b1, d, r);
  endtask

  task automatic rreg(input logic [7:0] i, output logic [31:0] r);
    xfer(i, 1'b0, 8'h00, r);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      rreg(IDX_PUMP_CONTROL_REG + 8'(i), r);
      check("reset value", r, 32'h0);
    end
    check("pump at reset", pump_enable, 1'b0);
    check("okay response", hresp, 1'b0);
    check("bus ready", hready, 1'b1);
  endtask

  task automatic t_conv(input logic al, input logic [1:0] rf, input logic sl);
    logic [31:0] r;
    logic [15:0] res;
    slow <= sl;
    sample <= 10'h2b5;
    res = al ? {6'h00, 10'h2b5} : {10'h2b5, 6'h00};
    wreg(IDX_ADC_CTRL_B, {al, 5'h00, rf});
    wreg(IDX_ADC_CTRL_A, 8'h97);
    rreg(IDX_ADC_CTRL_A, r);
    check("busy flag", r, 32'h97);
    check("channel", input_channel_sel, 6'h25);
    check("power", adc_power, 1'b1);
    check("reference", pos_ref_sel, rf);
    for (int n = 0; n < 40 && r[1] !== 1'b0; n++) rreg(IDX_ADC_CTRL_A, r);
    check("done flag", r, 32'h95);
    rreg(IDX_RESULT_HIGH_BYTE, r);
    check("result high", r, res[15:8]);
    rreg(IDX_RESULT_LOW_BYTE, r);
    check("result low", r, res[7:0]);
  endtask

  task automatic t_clk;
    int div[8] = '{2, 8, 32, 8, 4, 16, 64, 8};
    int cnt;
    wreg(IDX_ADC_CTRL_A, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wreg(IDX_ADC_CTRL_B, {1'b0, 3'(c), 4'h0});
      repeat (4) @(posedge hclk);
      cnt = 0;
      repeat (128) begin
        @(posedge hclk);
        if (conv_clk_en === 1'b1) cnt++;
      end
      check("clock rate", 32'(cnt >= 128 / div[c] - 1 && cnt <= 128 / div[c] + 1), 1);
    end
    wreg(IDX_ADC_CTRL_A, 8'h00);
    repeat (2) @(posedge hclk);
    check("clock when off", conv_clk_en, 1'b0);
  endtask

  task automatic t_trig;
    logic [31:0] r;
    int          n0;
    slow <= 1'b0;
    wreg(IDX_ADC_CTRL_A, 8'h01);
    for (int c = 0; c < 10; c++) begin
      wreg(IDX_AUTO_TRIGGER_SEL, 8'(c));
      n0 = starts;
      trigger_src <= (c == 0) ? 10'h3fe : (10'h001 << c);
      repeat (8) @(posedge hclk);
      check("trigger start", starts, n0 + (c != 0));
      trigger_src <= 10'h000;
      repeat (12) @(posedge hclk);
    end
    wreg(IDX_AUTO_TRIGGER_SEL, {4'h0, TRIG_HIGH_READ});
    n0 = starts;
    rreg(IDX_RESULT_HIGH_BYTE, r);
    repeat (3) @(posedge hclk);
    check("read trigger", starts, n0 + 1);
    repeat (12) @(posedge hclk);
  endtask

  task automatic t_pump;
    logic [31:0] r;
    logic        e;
    for (int k = 0; k < 16; k++) begin
      wreg(IDX_ADC_CTRL_A, {7'h00, k[2]});
      supply_below <= k[3];
      wreg(IDX_PUMP_CONTROL_REG, {k[1:0], 6'h00});
      repeat (5) @(posedge hclk);
      e = k[1:0] == 2'b11 || (k[1:0] == 2'b10 && k[3]) || (k[1:0] == 2'b01 && k[2] && k[3]);
      check("pump enable", pump_enable, e);
      rreg(IDX_PUMP_CONTROL_REG, r);
      check("pump mode", r, {24'h0, k[1:0], 6'h00});
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; hwrite = 0; rc_osc = 0; supply_below = 0; slow = 0;
    haddr = '0; htrans = 2'b00; hsize = 3'h2; hwdata = 32'h0; sample = 10'h000;
    trigger_src = '0; n_errors = 0; check_count = 0; cycles = 0; starts = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_conv(1'b1, 2'b11, 1'b1);
    t_conv(1'b0, 2'b10, 1'b0);
    t_clk();
    t_trig();
    t_pump();
    end_sim();
  end
endmodule

bind adcp_top adcp_properties chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .adc_power(adc_power), .input_channel_sel(input_channel_sel), .pos_ref_sel(pos_ref_sel),
  .conv_start(conv_start), .conv_clk_en(conv_clk_en), .pump_enable(pump_enable));
